// ---- rtl/fasq_pkg.sv ----
// Operation
// - the array disables every row while row enable is low, and standby holds all eight lines low.
// - the array disables its column multiplexer whenever column enable is low.
// - a read raises row, column, sense and data-drive enables only, and data out floats from the cycle after data-drive goes low.
// - with the block selector high, read, program and page erase use the information block and mass erase clears both, otherwise only the main block is used.
// - all set-up, hold, recovery, program, erase and mass-erase durations are programmable registers.
package fasq_pkg;
	localparam int CLK_MHZ = 25;
	// times as printed
	localparam int T_NVS_US = 5;
	localparam int T_NVH_US = 5;
	localparam int T_NVH1_US = 100;
	localparam int T_PGS_US = 10;
	localparam int T_REV_US = 1;
	localparam int T_CELL_WRITE_ENABLE_US = 20;
	localparam int T_ERASE_MS = 20;
	localparam int T_ME_MS = 100;
	// cycle counts
	localparam int NVS_CYC = T_NVS_US * CLK_MHZ;
	localparam int NVH_CYC = T_NVH_US * CLK_MHZ;
	localparam int NVH1_CYC = T_NVH1_US * CLK_MHZ;
	localparam int PGS_CYC = T_PGS_US * CLK_MHZ;
	localparam int REV_CYC = T_REV_US * CLK_MHZ;
	localparam int CELL_WRITE_ENABLE_CYC = T_CELL_WRITE_ENABLE_US * CLK_MHZ;
	localparam int ERASE_CYC = T_ERASE_MS * 1000 * CLK_MHZ;
	localparam int ME_CYC = T_ME_MS * 1000 * CLK_MHZ;
	// register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_TIM0 = 8'h20;
	localparam logic [7:0] REG_TIM_LAST = 8'h3C;
	// timing register index
	localparam int TI_NVS = 0;
	localparam int TI_NVH = 1;
	localparam int TI_NVH1 = 2;
	localparam int TI_PGS = 3;
	localparam int TI_REV = 4;
	localparam int TI_CELL_WRITE_ENABLE = 5;
	localparam int TI_ERASE = 6;
	localparam int TI_ME = 7;
	localparam int N_TIM = 8;
	// fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_INFO_BIT = 3;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ERR_BIT = 1;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	typedef enum logic [2:0] {OP_NONE, OP_READ, OP_CELL_WRITE_ENABLE, OP_PERASE, OP_MERASE} fasq_op_t;
	typedef enum logic [2:0] {S_IDLE, S_READ, S_RDLAT, S_SETUP, S_STROBE, S_PULSE, S_HOLD,
		S_RECOVER} fasq_state_t;
	typedef struct packed {
		logic row_addr_enable;
		logic column_addr_enable;
		logic sense_amp_enable;
		logic data_drive_enable;
		logic cell_write_enable;
		logic clear_enable;
		logic whole_block_select;
		logic store_strobe;
	} fasq_ctrl_t;
endpackage

// ---- rtl/fasq_top.sv ----
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
module fasq_top #(
	parameter int MAIN_WORDS = 64,
	parameter int INFO_WORDS = 16,
	parameter int PAGE_WORDS = 8,
	parameter int ERASE_CYC = fasq_pkg::ERASE_CYC,
	parameter int ME_CYC = fasq_pkg::ME_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// array control lines and data out
	output fasq_pkg::fasq_ctrl_t flash_ctrl,
	output logic [15:0] array_data_out,
	output logic array_data_out_en
);
	localparam int NW = MAIN_WORDS + INFO_WORDS;

	fasq_pkg::fasq_state_t state_r, state_nxt;
	fasq_pkg::fasq_op_t op_r, op_nxt;
	fasq_pkg::fasq_ctrl_t ctrl_r, ctrl_nxt;
	logic info_r, info_nxt, err_r, err_nxt, ack_r, ack_nxt;
	logic [15:0] addr_r, addr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [31:0] cnt_r, cnt_nxt, rdbus_r, rdbus_nxt;
	logic [31:0] tim_r [fasq_pkg::N_TIM];
	logic [31:0] tim_nxt [fasq_pkg::N_TIM];
	logic [NW-1:0] pgm_r, pgm_nxt;
	logic [15:0] main_mem [MAIN_WORDS];
	logic [15:0] info_mem [INFO_WORDS];
	logic [15:0] dout_r;
	logic dout_en_r;
	logic do_cell_write_enable, do_erase, wr_take;

	// register decode shared by reads and writes
	function automatic logic is_tim(input logic [7:0] a);
		return a >= fasq_pkg::REG_TIM0 && a <= fasq_pkg::REG_TIM_LAST && a[1:0] == 2'h0;
	endfunction

	function automatic int tidx(input logic [7:0] a);
		return int'(a - fasq_pkg::REG_TIM0) >> 2;
	endfunction

	function automatic logic [31:0] load(input logic [31:0] t);
		return (t == 32'h0) ? 32'h0 : t - 32'h1;
	endfunction

	function automatic int widx(input logic inf, input logic [15:0] a);
		return inf ? MAIN_WORDS + int'(a) % INFO_WORDS : int'(a) % MAIN_WORDS;
	endfunction

	// line pattern for each step
	function automatic fasq_pkg::fasq_ctrl_t pattern(input fasq_pkg::fasq_state_t s,
		input fasq_pkg::fasq_op_t op);
		fasq_pkg::fasq_ctrl_t c;
		logic er;
		c = '0;
		er = (op == fasq_pkg::OP_PERASE) || (op == fasq_pkg::OP_MERASE);
		case (s)
			fasq_pkg::S_READ, fasq_pkg::S_RDLAT: begin
				c.row_addr_enable = 1'b1;
				c.column_addr_enable = 1'b1;
				c.sense_amp_enable = 1'b1;
				c.data_drive_enable = 1'b1;
			end
			fasq_pkg::S_SETUP, fasq_pkg::S_STROBE, fasq_pkg::S_PULSE, fasq_pkg::S_HOLD: begin
				c.row_addr_enable = 1'b1;
				c.cell_write_enable = !er && s != fasq_pkg::S_HOLD;
				c.clear_enable = er && s != fasq_pkg::S_HOLD;
				c.whole_block_select = op == fasq_pkg::OP_MERASE;
				c.store_strobe = s != fasq_pkg::S_SETUP;
				c.column_addr_enable = !er && s == fasq_pkg::S_PULSE;
			end
			default: c = '0;
		endcase
		return c;
	endfunction

	// sequencer and registers
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		info_nxt = info_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		pgm_nxt = pgm_r;
		tim_nxt = tim_r;
		cnt_nxt = (cnt_r == 32'h0) ? 32'h0 : cnt_r - 32'h1;
		do_cell_write_enable = 1'b0;
		do_erase = 1'b0;
		ack_nxt = (avs_read || avs_write) && !ack_r;
		wr_take = avs_write && ack_r;
		rdbus_nxt = 32'h0;
		case (avs_address)
			fasq_pkg::REG_CMD: rdbus_nxt = {29'h0, op_r};
			fasq_pkg::REG_ADDR: rdbus_nxt = {16'h0, addr_r};
			fasq_pkg::REG_WDATA: rdbus_nxt = {16'h0, wdata_r};
			fasq_pkg::REG_RDATA: rdbus_nxt = {16'h0, rdata_r};
			fasq_pkg::REG_STATUS: rdbus_nxt = {30'h0, err_r, state_r != fasq_pkg::S_IDLE};
			default: rdbus_nxt = is_tim(avs_address) ? tim_r[tidx(avs_address)] : 32'h0;
		endcase
		if (wr_take && state_r == fasq_pkg::S_IDLE) begin
			if (avs_address == fasq_pkg::REG_ADDR) addr_nxt = avs_writedata[15:0];
			if (avs_address == fasq_pkg::REG_WDATA) wdata_nxt = avs_writedata[15:0];
			if (is_tim(avs_address)) tim_nxt[tidx(avs_address)] = avs_writedata;
		end
		if (wr_take && avs_address == fasq_pkg::REG_STATUS && avs_writedata[fasq_pkg::ST_ERR_BIT])
			err_nxt = 1'b0;
		case (state_r)
			fasq_pkg::S_IDLE: begin
				if (wr_take && avs_address == fasq_pkg::REG_CMD) begin
					op_nxt = fasq_pkg::fasq_op_t'(avs_writedata[fasq_pkg::CMD_OP_LSB +: 3]);
					info_nxt = avs_writedata[fasq_pkg::CMD_INFO_BIT];
					cnt_nxt = load(tim_r[fasq_pkg::TI_NVS]);
					case (op_nxt)
						fasq_pkg::OP_READ: state_nxt = fasq_pkg::S_READ;
						fasq_pkg::OP_CELL_WRITE_ENABLE: begin
							if (pgm_r[widx(info_nxt, addr_r)]) begin
								err_nxt = 1'b1;
							end else begin
								state_nxt = fasq_pkg::S_SETUP;
							end
						end
						fasq_pkg::OP_PERASE, fasq_pkg::OP_MERASE: state_nxt = fasq_pkg::S_SETUP;
						default: state_nxt = fasq_pkg::S_IDLE;
					endcase
				end
			end
			fasq_pkg::S_READ: state_nxt = fasq_pkg::S_RDLAT;
			fasq_pkg::S_RDLAT: begin
				rdata_nxt = dout_r;
				state_nxt = fasq_pkg::S_IDLE;
			end
			fasq_pkg::S_SETUP: begin
				if (cnt_r == 32'h0) begin
					if (op_r == fasq_pkg::OP_CELL_WRITE_ENABLE) begin
						state_nxt = fasq_pkg::S_STROBE;
						cnt_nxt = load(tim_r[fasq_pkg::TI_PGS]);
					end else begin
						state_nxt = fasq_pkg::S_PULSE;
						cnt_nxt = load(tim_r[(op_r == fasq_pkg::OP_MERASE) ?
							fasq_pkg::TI_ME : fasq_pkg::TI_ERASE]);
					end
				end
			end
			fasq_pkg::S_STROBE: begin
				if (cnt_r == 32'h0) begin
					state_nxt = fasq_pkg::S_PULSE;
					cnt_nxt = load(tim_r[fasq_pkg::TI_CELL_WRITE_ENABLE]);
				end
			end
			fasq_pkg::S_PULSE: begin
				if (cnt_r == 32'h0) begin
					state_nxt = fasq_pkg::S_HOLD;
					cnt_nxt = load(tim_r[(op_r == fasq_pkg::OP_MERASE) ?
						fasq_pkg::TI_NVH1 : fasq_pkg::TI_NVH]);
					do_cell_write_enable = op_r == fasq_pkg::OP_CELL_WRITE_ENABLE;
					do_erase = op_r != fasq_pkg::OP_CELL_WRITE_ENABLE;
					if (do_cell_write_enable) pgm_nxt[widx(info_r, addr_r)] = 1'b1;
					for (int i = 0; i < NW; i++) begin
						if (do_erase && (op_r == fasq_pkg::OP_MERASE ?
							(i < MAIN_WORDS || info_r) :
							(widx(info_r, addr_r) / PAGE_WORDS == i / PAGE_WORDS &&
							(i >= MAIN_WORDS) == info_r))) pgm_nxt[i] = 1'b0;
					end
				end
			end
			fasq_pkg::S_HOLD: begin
				if (cnt_r == 32'h0) begin
					state_nxt = fasq_pkg::S_RECOVER;
					cnt_nxt = load(tim_r[fasq_pkg::TI_REV]);
				end
			end
			fasq_pkg::S_RECOVER: if (cnt_r == 32'h0) state_nxt = fasq_pkg::S_IDLE;
			default: state_nxt = fasq_pkg::S_IDLE;
		endcase
		ctrl_nxt = pattern(state_nxt, op_nxt);
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= fasq_pkg::S_IDLE;
			op_r <= fasq_pkg::OP_NONE;
			ctrl_r <= '0;
			info_r <= 1'b0;
			err_r <= 1'b0;
			ack_r <= 1'b0;
			addr_r <= 16'h0;
			wdata_r <= 16'h0;
			rdata_r <= 16'h0;
			cnt_r <= 32'h0;
			rdbus_r <= 32'h0;
			pgm_r <= '0;
			tim_r[fasq_pkg::TI_NVS] <= 32'(fasq_pkg::NVS_CYC);
			tim_r[fasq_pkg::TI_NVH] <= 32'(fasq_pkg::NVH_CYC);
			tim_r[fasq_pkg::TI_NVH1] <= 32'(fasq_pkg::NVH1_CYC);
			tim_r[fasq_pkg::TI_PGS] <= 32'(fasq_pkg::PGS_CYC);
			tim_r[fasq_pkg::TI_REV] <= 32'(fasq_pkg::REV_CYC);
			tim_r[fasq_pkg::TI_CELL_WRITE_ENABLE] <= 32'(fasq_pkg::CELL_WRITE_ENABLE_CYC);
			tim_r[fasq_pkg::TI_ERASE] <= 32'(ERASE_CYC);
			tim_r[fasq_pkg::TI_ME] <= 32'(ME_CYC);
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			ctrl_r <= ctrl_nxt;
			info_r <= info_nxt;
			err_r <= err_nxt;
			ack_r <= ack_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			cnt_r <= cnt_nxt;
			rdbus_r <= rdbus_nxt;
			pgm_r <= pgm_nxt;
			tim_r <= tim_nxt;
		end
	end

	// flash array cells, written on do_cell_write_enable gated by column and strobe lines, erased on do_erase
	always_ff @(posedge mclk) begin
		if (do_cell_write_enable && ctrl_r.column_addr_enable && ctrl_r.store_strobe) begin
			if (info_r) info_mem[int'(addr_r) % INFO_WORDS] <= wdata_r;
			else main_mem[int'(addr_r) % MAIN_WORDS] <= wdata_r;
		end
		for (int i = 0; i < MAIN_WORDS; i++) begin
			if (do_erase && (ctrl_r.whole_block_select || (!info_r &&
				i / PAGE_WORDS == int'(addr_r) % MAIN_WORDS / PAGE_WORDS)))
				main_mem[i] <= fasq_pkg::ERASED_WORD;
		end
		for (int i = 0; i < INFO_WORDS; i++) begin
			if (do_erase && info_r && (ctrl_r.whole_block_select ||
				i / PAGE_WORDS == int'(addr_r) % INFO_WORDS / PAGE_WORDS))
				info_mem[i] <= fasq_pkg::ERASED_WORD;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dout_r <= 16'h0;
			dout_en_r <= 1'b0;
		end else begin
			dout_en_r <= ctrl_r.data_drive_enable;
			if (ctrl_r.row_addr_enable && ctrl_r.column_addr_enable && ctrl_r.sense_amp_enable)
				dout_r <= info_r ? info_mem[int'(addr_r) % INFO_WORDS] :
					main_mem[int'(addr_r) % MAIN_WORDS];
		end
	end

	assign flash_ctrl = ctrl_r;
	assign array_data_out = dout_r;
	assign array_data_out_en = dout_en_r;
	assign avs_readdata = rdbus_r;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence strobe_rise;
		$rose(flash_ctrl.store_strobe);
	endsequence

	standby_all_low_a: assert property (state_r == fasq_pkg::S_IDLE |-> flash_ctrl == '0)
		else $error("control lines not low in standby");
	read_pattern_a: assert property (state_r == fasq_pkg::S_READ |-> flash_ctrl == 8'hF0)
		else $error("read line pattern wrong");
	float_when_off_a: assert property (!flash_ctrl.data_drive_enable |=> !array_data_out_en)
		else $error("data out driven while data-drive low");
	column_gated_a: assert property (!flash_ctrl.column_addr_enable |=> $stable(dout_r))
		else $error("column data changed with column enable low");
	setup_before_strobe_a: assert property (strobe_rise |->
		$past(flash_ctrl.cell_write_enable || flash_ctrl.clear_enable))
		else $error("store strobe rose without set-up");
	mass_select_a: assert property (op_r == fasq_pkg::OP_MERASE && state_r == fasq_pkg::S_PULSE
		|-> flash_ctrl.whole_block_select && flash_ctrl.clear_enable)
		else $error("mass erase pattern wrong");
	timing_write_a: assert property (avs_write && !avs_waitrequest && is_tim(avs_address) &&
		state_r == fasq_pkg::S_IDLE |=> tim_r[tidx($past(avs_address))] ==
		$past(avs_writedata))
		else $error("timing register not written");
	double_cell_write_enable_a: assert property (state_r == fasq_pkg::S_SETUP && op_r == fasq_pkg::OP_CELL_WRITE_ENABLE
		|-> !pgm_r[widx(info_r, addr_r)])
		else $error("word programmed twice");
endmodule

// ---- tb/fasq_array_model.sv ----
`timescale 1ns/1ns
module fasq_array_model (
	// clock
	input wire logic mclk,
	// array data side
	input wire logic [15:0] array_data_out,
	input wire logic array_data_out_en,
	// bus as seen by a reader
	output logic [15:0] data_bus
);
	logic [15:0] last_r = 16'h5A5A;
	// a floated bus keeps changing instead of holding the last word
	always_ff @(posedge mclk) begin
		last_r <= array_data_out_en ? array_data_out : ~last_r;
	end
	assign data_bus = array_data_out_en ? array_data_out : last_r;
endmodule

// ---- tb/tb_flash_array_control_sequencer.sv ----
`timescale 1ns/1ns
module tb_flash_array_control_sequencer;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	fasq_pkg::fasq_ctrl_t flash_ctrl;
	logic [15:0] array_data_out;
	logic array_data_out_en;
	logic [15:0] data_bus;
	logic [31:0] d;
	logic [31:0] bw;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int tv[6] = '{3, 2, 4, 3, 2, 5};

	fasq_top #(.ERASE_CYC(20), .ME_CYC(50)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .flash_ctrl(flash_ctrl),
		.array_data_out(array_data_out), .array_data_out_en(array_data_out_en));
	fasq_array_model model_u (.mclk(mclk), .array_data_out(array_data_out),
		.array_data_out_en(array_data_out_en), .data_bus(data_bus));

	always #20 mclk = ~mclk;

	task end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			$display("ERROR %0t: run did not finish", $time);
			end_of_test;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	// runs a command and checks each line pattern and how many cycles it stands
	task op(input logic [31:0] cmd, input logic [31:0] pat, input logic [31:0] len);
		int i;
		int n;
		wr(fasq_pkg::REG_CMD, cmd);
		@(negedge mclk);
		for (i = 0; i < 4; i++) begin
			if (pat[31-8*i -: 8] != 8'h00) begin
				n = 0;
				while (flash_ctrl === pat[31-8*i -: 8] && n < 300) begin
					n++;
					@(negedge mclk);
				end
				if (len[31-8*i -: 8] != 8'h00) chk(32'(n), 32'(len[31-8*i -: 8]));
				else chk(32'(n > 0), 32'h1);
			end
		end
		bw = {15'h0000, array_data_out_en, data_bus};
		chk({24'h000000, flash_ctrl}, 32'h00000000);
		do rd(fasq_pkg::REG_STATUS); while (d[0] !== 1'b0);
	endtask

	// data out still drives the word in the first idle cycle after a read
	task rd_word(input logic [31:0] cmd, input logic [31:0] exp);
		op(cmd, 32'hF0000000, 32'h02000000);
		chk(bw, {15'h0000, 1'b1, exp[15:0]});
		rchk(fasq_pkg::REG_RDATA, exp);
	endtask

	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		@(negedge mclk);
		chk({24'h000000, flash_ctrl}, 32'h00000000);
		chk({31'h0, array_data_out_en}, 32'h00000000);
		rchk(fasq_pkg::REG_STATUS, 32'h00000000);
		$display("test reset done");
		for (int i = 0; i < 6; i++) wr(fasq_pkg::REG_TIM0 + 8'(4 * i), 32'(tv[i]));
		for (int i = 0; i < 6; i++) rchk(fasq_pkg::REG_TIM0 + 8'(4 * i), 32'(tv[i]));
		$display("test timing registers done");
		op(32'h0000000C, 32'h86878300, 32'h03320400);
		$display("test mass erase both done");
		wr(fasq_pkg::REG_ADDR, 32'h00000005);
		wr(fasq_pkg::REG_WDATA, 32'h00001234);
		op(32'h00000002, 32'h8889C981, 32'h03030502);
		rchk(fasq_pkg::REG_ADDR, 32'h00000005);
		wr(fasq_pkg::REG_WDATA, 32'h0000ABCD);
		op(32'h0000000A, 32'h8889C981, 32'h03030502);
		rd_word(32'h00000001, 32'h00001234);
		rd_word(32'h00000009, 32'h0000ABCD);
		$display("test program and read done");
		wr(fasq_pkg::REG_WDATA, 32'h00005555);
		wr(fasq_pkg::REG_CMD, 32'h00000002);
		@(negedge mclk);
		chk({24'h000000, flash_ctrl}, 32'h00000000);
		rchk(fasq_pkg::REG_STATUS, 32'h00000002);
		wr(fasq_pkg::REG_STATUS, 32'h00000002);
		rchk(fasq_pkg::REG_STATUS, 32'h00000000);
		rd_word(32'h00000001, 32'h00001234);
		$display("test double program done");
		op(32'h00000003, 32'h84858100, 32'h03140200);
		rd_word(32'h00000001, {16'h0000, fasq_pkg::ERASED_WORD});
		rd_word(32'h00000009, 32'h0000ABCD);
		op(32'h00000004, 32'h86878300, 32'h03320400);
		rd_word(32'h00000009, 32'h0000ABCD);
		$display("test erase done");
		wr(fasq_pkg::REG_CMD, 32'h00000004);
		@(posedge mclk);
		sys_rst <= 1'b1;
		@(negedge mclk);
		chk({24'h000000, flash_ctrl}, 32'h00000000);
		@(posedge mclk);
		sys_rst <= 1'b0;
		rchk(fasq_pkg::REG_STATUS, 32'h00000000);
		rchk(fasq_pkg::REG_TIM0, 32'(fasq_pkg::NVS_CYC));
		$display("test reset in operation done");
		wr(fasq_pkg::REG_CMD, 32'h00000000);
		@(negedge mclk);
		chk({24'h000000, flash_ctrl}, 32'h00000000);
		rchk(fasq_pkg::REG_STATUS, 32'h00000000);
		wr(8'h40, 32'hFFFFFFFF);
		rchk(8'h40, 32'h00000000);
		$display("test unmapped done");
		end_of_test;
	end
endmodule
